// ===== emcf_cfg.svh
// register offsets, field positions and reset values of the mac config and hash filter block
`ifndef EMCF_CFG_SVH
`define EMCF_CFG_SVH
`define EMCF_OFS_HASH_LOW 8'h00
`define EMCF_OFS_HASH_HIGH 8'h04
`define EMCF_OFS_CFG_ONE 8'h08
`define EMCF_OFS_CTRL 8'h0c
`define EMCF_BIT_WHOLE_RST 15
`define EMCF_BIT_BACKOFF_RST 14
`define EMCF_BIT_CSL_RX_RST 11
`define EMCF_BIT_RX_FUN_RST 10
`define EMCF_BIT_CSL_TX_RST 9
`define EMCF_BIT_TX_FUN_RST 8
`define EMCF_BIT_LOOPBACK 4
`define EMCF_BIT_TX_PAUSE 3
`define EMCF_BIT_RX_PAUSE 2
`define EMCF_BIT_PASS_ALL 1
`define EMCF_BIT_RX_ON 0
`define EMCF_CFG_MASK 32'h0000cf1f
`define EMCF_CFG_RESET 32'h0000800d
`define EMCF_BIT_RX_PATH_ON 0
`define EMCF_BIT_HASH_ON 1
`define EMCF_CTRL_MASK 32'h00000003
`define EMCF_CTRL_RESET 32'h00000000
`define EMCF_HASH_RESET 32'h00000000
`endif

// ===== emcf_pkg.sv
// types shared by the mac config and hash filter block
package emcf_pkg;
  typedef enum logic [1:0] {
    EMCF_RX_IDLE = 2'b00,
    EMCF_RX_FRAME = 2'b01,
    EMCF_RX_DROP = 2'b10
  } emcf_rx_state_t;
endpackage

// ===== emcf_top.sv
// mac configuration, domain resets, loopback, pause gating and receive hash filter
`include "emcf_cfg.svh"
`timescale 1ns/1ns
module emcf_top #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // register bus, read data one cycle after the strobe
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // transmit side from the internal frame path
  input wire logic tx_valid,
  input wire logic tx_pause_frame,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  // receive side from the phy interface
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_is_control,
  input wire logic rx_is_pause,
  input wire logic rx_is_group,
  input wire logic [5:0] rx_hash_index,
  // transmit toward the phy
  output logic phy_tx_valid,
  output logic [7:0] phy_tx_data,
  output logic phy_tx_last,
  // receive toward the internal frame path
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic rx_out_last,
  output logic tx_paused,
  // domain resets, active high, for the surrounding mac logic
  output logic mac_media_rst,
  output logic backoff_rng_rst,
  output logic csl_rx_rst,
  output logic csl_tx_rst,
  output logic rx_fun_rst,
  output logic tx_fun_rst
);
  import emcf_pkg::*;

  // the highest register offset must fit in the address
  initial begin
    if (ADDR_W < 4 || ADDR_W > 32) begin
      $error("emcf_top: ADDR_W must lie between 4 and 32");
    end
  end


  // all state lives in one packed struct so a single flop process covers it
  // hash_lo, hash_hi: receive hash table words, owned by software
  // cfg: mac config word, unimplemented bits held at zero by the write mask
  // ctrl: receive path and hash filter enables, standing in for the outer switches
  // rdata: read answer, zero outside the cycle after a read strobe
  // rx_*: receive output stage, one byte per cycle
  // tx_*: transmit register stage shared by the phy side and loopback
  // paused: a received pause frame is being obeyed
  typedef struct packed {
    logic [31:0] hash_lo;
    logic [31:0] hash_hi;
    logic [31:0] cfg;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    emcf_rx_state_t rx_state;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_last;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic paused;
  } emcf_state_t;

  emcf_state_t s_q;
  emcf_state_t s_d;


  // one decode shared by read and write paths
  // addresses that hit nothing decode as the low word; addr_hit guards that
  // case so an unmapped write cannot land in the table
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] r;
    r = 2'b00;
    if (a == ADDR_W'(`EMCF_OFS_HASH_HIGH)) r = 2'b01;
    else if (a == ADDR_W'(`EMCF_OFS_CFG_ONE)) r = 2'b10;
    else if (a == ADDR_W'(`EMCF_OFS_CTRL)) r = 2'b11;
    return r;
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(`EMCF_OFS_HASH_LOW) || a == ADDR_W'(`EMCF_OFS_HASH_HIGH) ||
           a == ADDR_W'(`EMCF_OFS_CFG_ONE) || a == ADDR_W'(`EMCF_OFS_CTRL);
  endfunction


  // decoded config fields, named after what they switch
  logic whole_mac_reset;
  logic mac_receive_on;
  logic accept_control_frames;
  logic rx_flow_ctrl_obey;
  logic tx_flow_ctrl_allow;
  logic loop_on;
  logic rx_path_on;
  logic hash_filter_on;
  logic rx_reset;
  logic tx_reset;
  logic hash_lock;
  logic [63:0] hash_bits;
  logic lb_valid;
  logic [7:0] lb_data;
  logic lb_last;
  logic lb_control;
  logic lb_pause;
  logic lb_group;
  logic frame_ok;
  logic tx_gate;

  always_comb begin
    whole_mac_reset = s_q.cfg[`EMCF_BIT_WHOLE_RST];
    mac_receive_on = s_q.cfg[`EMCF_BIT_RX_ON];
    accept_control_frames = s_q.cfg[`EMCF_BIT_PASS_ALL];
    rx_flow_ctrl_obey = s_q.cfg[`EMCF_BIT_RX_PAUSE];
    tx_flow_ctrl_allow = s_q.cfg[`EMCF_BIT_TX_PAUSE];
    loop_on = s_q.cfg[`EMCF_BIT_LOOPBACK];
    rx_path_on = s_q.ctrl[`EMCF_BIT_RX_PATH_ON];
    hash_filter_on = s_q.ctrl[`EMCF_BIT_HASH_ON];
    // domain resets follow the bits as levels; the whole reset covers every domain except the backoff generator
    rx_reset = whole_mac_reset | s_q.cfg[`EMCF_BIT_RX_FUN_RST] |
               s_q.cfg[`EMCF_BIT_CSL_RX_RST];
    tx_reset = whole_mac_reset | s_q.cfg[`EMCF_BIT_TX_FUN_RST] |
               s_q.cfg[`EMCF_BIT_CSL_TX_RST];
    // table writes are dropped while the filter is live, so a stray write cannot glitch it
    hash_lock = rx_path_on & hash_filter_on;
    hash_bits = {s_q.hash_hi, s_q.hash_lo};
  end


  // receive source: phy input or looped transmit stream
  // loopback takes the registered transmit bytes; the phy flags mean nothing
  // for looped traffic, so they are forced to those of a plain frame
  always_comb begin
    if (loop_on) begin
      lb_valid = s_q.tx_valid;
      lb_data = s_q.tx_data;
      lb_last = s_q.tx_last;
      lb_control = 1'b0;
      lb_pause = 1'b0;
      lb_group = 1'b0;
    end else begin
      lb_valid = rx_valid;
      lb_data = rx_data;
      lb_last = rx_last;
      lb_control = rx_is_control;
      lb_pause = rx_is_pause;
      lb_group = rx_is_group;
    end
  end


  // accept decision, taken on the first byte of a frame
  // group frames need their table bit set once hash filtering is on; unicast
  // and broadcast address matching lie outside this block
  always_comb begin
    frame_ok = mac_receive_on & rx_path_on;
    if (lb_control && !accept_control_frames) begin
      frame_ok = 1'b0;
    end
    // the hash filter only looks at receive traffic
    if (hash_filter_on && lb_group && !hash_bits[rx_hash_index]) begin
      frame_ok = 1'b0;
    end
    // pause frames are held back only while their transmission is blocked
    tx_gate = tx_valid & ~(tx_pause_frame & ~tx_flow_ctrl_allow);
  end


  // next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    // register writes
    // reads and writes share the decode; the master never issues both at once,
    // and if it did the read would simply return the old value
    if (reg_wr) begin
      case (reg_sel(reg_addr))
        2'b00: begin
          if (addr_hit(reg_addr) && !hash_lock) s_d.hash_lo = reg_wdata;
        end
        2'b01: begin
          if (!hash_lock) s_d.hash_hi = reg_wdata;
        end
        2'b10: s_d.cfg = reg_wdata & `EMCF_CFG_MASK;
        2'b11: s_d.ctrl = reg_wdata & `EMCF_CTRL_MASK;
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    // read data stand in the cycle after the strobe only
    if (reg_rd && addr_hit(reg_addr)) begin
      case (reg_sel(reg_addr))
        2'b00: s_d.rdata = s_q.hash_lo;
        2'b01: s_d.rdata = s_q.hash_hi;
        2'b10: s_d.rdata = s_q.cfg & `EMCF_CFG_MASK;
        2'b11: s_d.rdata = s_q.ctrl;
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    // transmit register stage
    // kept in loopback too, so looped bytes pass the same one-cycle stage
    // as bytes that leave on the wire, then one more cycle in the receive stage
    s_d.tx_valid = tx_gate;
    s_d.tx_data = tx_data;
    s_d.tx_last = tx_last;
    if (tx_reset) begin
      s_d.tx_valid = 1'b0;
      s_d.tx_last = 1'b0;
      s_d.tx_data = 8'h00;
    end

    // receive state machine, one byte per valid
    // the accept decision is made once on the first byte; the rest of a
    // dropped frame is swallowed in the drop state until its last byte
    // limitation: a frame cut off with no last byte keeps the machine in its
    // state until the next last byte arrives
    s_d.rx_valid = 1'b0;
    s_d.rx_last = 1'b0;
    case (s_q.rx_state)
      EMCF_RX_IDLE: begin
        if (lb_valid) begin
          if (frame_ok) begin
            s_d.rx_valid = 1'b1;
            s_d.rx_data = lb_data;
            s_d.rx_last = lb_last;
            s_d.rx_state = lb_last ? EMCF_RX_IDLE : EMCF_RX_FRAME;
          end else begin
            s_d.rx_state = lb_last ? EMCF_RX_IDLE : EMCF_RX_DROP;
          end
          if (lb_pause && rx_flow_ctrl_obey) s_d.paused = 1'b1;
        end
      end
      EMCF_RX_FRAME: begin
        if (lb_valid) begin
          s_d.rx_valid = 1'b1;
          s_d.rx_data = lb_data;
          s_d.rx_last = lb_last;
          if (lb_last) s_d.rx_state = EMCF_RX_IDLE;
        end
      end
      EMCF_RX_DROP: begin
        if (lb_valid && lb_last) s_d.rx_state = EMCF_RX_IDLE;
      end
      default: s_d.rx_state = EMCF_RX_IDLE;
    endcase

    // pause is lifted once software stops obeying it or the next frame ends
    // a new pause frame in the same cycle as the end of a transmit frame
    // keeps the pause: the fresh request wins over the release
    if (!rx_flow_ctrl_obey) s_d.paused = 1'b0;
    else if (s_q.paused && s_q.tx_valid && s_q.tx_last &&
             !(s_q.rx_state == EMCF_RX_IDLE && lb_valid && lb_pause)) s_d.paused = 1'b0;
    // the receive reset also drops a pending pause, so nothing stays stuck
    if (rx_reset) begin
      s_d.rx_state = EMCF_RX_IDLE;
      s_d.rx_valid = 1'b0;
      s_d.rx_last = 1'b0;
      s_d.rx_data = 8'h00;
      s_d.paused = 1'b0;
    end
  end


  // single state register; clk_en freezes everything
  // trade-off: gating every flop with clk_en keeps the domains in step,
  // at the cost of losing strobes that arrive while it is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q.hash_lo <= `EMCF_HASH_RESET;
      s_q.hash_hi <= `EMCF_HASH_RESET;
      s_q.cfg <= `EMCF_CFG_RESET;
      s_q.ctrl <= `EMCF_CTRL_RESET;
      s_q.rdata <= 32'h00000000;
      s_q.rx_state <= EMCF_RX_IDLE;
      s_q.rx_valid <= 1'b0;
      s_q.rx_data <= 8'h00;
      s_q.rx_last <= 1'b0;
      s_q.tx_valid <= 1'b0;
      s_q.tx_data <= 8'h00;
      s_q.tx_last <= 1'b0;
      s_q.paused <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end


  // outputs
  // domain resets are plain decodes of the config word, so they follow
  // the bits as levels with no extra delay
  always_comb begin
    reg_rdata = s_q.rdata;
    // looped traffic does not also leave on the wire
    phy_tx_valid = s_q.tx_valid & ~loop_on & ~s_q.paused;
    phy_tx_data = s_q.tx_data;
    phy_tx_last = s_q.tx_last & ~loop_on;
    rx_out_valid = s_q.rx_valid;
    rx_out_data = s_q.rx_data;
    rx_out_last = s_q.rx_last;
    tx_paused = s_q.paused;
    mac_media_rst = whole_mac_reset;
    backoff_rng_rst = s_q.cfg[`EMCF_BIT_BACKOFF_RST];
    csl_rx_rst = whole_mac_reset | s_q.cfg[`EMCF_BIT_CSL_RX_RST];
    rx_fun_rst = whole_mac_reset | s_q.cfg[`EMCF_BIT_RX_FUN_RST];
    csl_tx_rst = whole_mac_reset | s_q.cfg[`EMCF_BIT_CSL_TX_RST];
    tx_fun_rst = whole_mac_reset | s_q.cfg[`EMCF_BIT_TX_FUN_RST];
  end
endmodule

// ===== emcf_phy_model.sv
// behavioural phy receive side feeding frames into the mac
`timescale 1ns/1ns
module emcf_phy_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_is_control,
  output logic rx_is_pause,
  output logic rx_is_group,
  output logic [5:0] rx_hash_index
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    {rx_is_control, rx_is_pause, rx_is_group} = 3'h0;
    rx_hash_index = 6'h00;
  end

  // one frame of n bytes counting up from d0; flags are {control, pause, group}
  task send(input int n, input logic [2:0] f, input logic [5:0] ix, input logic [7:0] d0);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= d0 + 8'(i);
      rx_last <= (i == n - 1);
      {rx_is_control, rx_is_pause, rx_is_group} <= f;
      rx_hash_index <= ix;
    end
    // between frames the lines show the inverse, so stale data cannot pass for valid
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
    {rx_is_control, rx_is_pause, rx_is_group} <= ~f;
    rx_hash_index <= ~ix;
  endtask
endmodule

// ===== emcf_top_asserts.sv
// concurrent checks on the ports of the mac config and hash filter block
`timescale 1ns/1ns
module emcf_top_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic phy_tx_valid,
  input wire logic [7:0] phy_tx_data,
  input wire logic rx_out_valid,
  input wire logic rx_out_last,
  input wire logic tx_paused,
  input wire logic mac_media_rst,
  input wire logic backoff_rng_rst,
  input wire logic csl_rx_rst,
  input wire logic csl_tx_rst,
  input wire logic rx_fun_rst,
  input wire logic tx_fun_rst
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // read data stand one cycle only, so a stale word cannot be taken twice
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  cfg_mask_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08 |-> (reg_rdata & 32'hffff30e0) == 32'h0)
    else $error("unimplemented config bits read nonzero");
  whole_rst_a: assert property (mac_media_rst |-> csl_rx_rst && csl_tx_rst && rx_fun_rst && tx_fun_rst)
    else $error("whole reset does not cover all domains");
  backoff_rise_a: assert property ($rose(backoff_rng_rst) |-> $past(reg_wr) && $past(reg_addr) == 8'h08 && $past(reg_wdata[14]))
    else $error("backoff reset rose without a config write");
  rx_hold_a: assert property (rx_fun_rst && $past(rx_fun_rst) |-> !rx_out_valid)
    else $error("receive output during receive reset");
  tx_hold_a: assert property (tx_fun_rst && $past(tx_fun_rst) |-> !phy_tx_valid)
    else $error("transmit output during transmit reset");
  pause_block_a: assert property (tx_paused |-> !phy_tx_valid)
    else $error("transmit while paused");
  tx_pipe_a: assert property (phy_tx_valid |-> $past(tx_valid) && phy_tx_data == $past(tx_data))
    else $error("transmit byte not the one taken a cycle before");
  rst_level_a: assert property ($changed(csl_tx_rst) |-> $past(reg_wr) && $past(reg_addr) == 8'h08)
    else $error("domain reset changed without a config write");
  cover property (rx_out_last);
  cover property (tx_paused);
  cover property ($rose(backoff_rng_rst));
endmodule

bind emcf_top emcf_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== tb.sv
// self-checking bench for the mac config and hash filter block
`timescale 1ns/1ns
module tb;
  import emcf_pkg::*;
  logic sys_clk = 0, rstn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic tx_valid = 0, tx_pause_frame = 0, tx_last = 0;
  logic [7:0] reg_addr = 8'h00, tx_data = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, h0, h1;
  logic rx_valid, rx_last, rx_is_control, rx_is_pause, rx_is_group;
  logic [7:0] rx_data, rx_out_data, phy_tx_data;
  logic [5:0] rx_hash_index, rst_out;
  logic phy_tx_valid, phy_tx_last, rx_out_valid, rx_out_last, tx_paused;
  logic [31:0] regq[$];
  logic [8:0] rxq[$], txq[$];
  int fails = 0, samples_checked = 0, cyc = 0;
  emcf_top dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_valid(tx_valid), .tx_pause_frame(tx_pause_frame), .tx_data(tx_data), .tx_last(tx_last),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_is_control(rx_is_control),
    .rx_is_pause(rx_is_pause), .rx_is_group(rx_is_group), .rx_hash_index(rx_hash_index),
    .phy_tx_valid(phy_tx_valid), .phy_tx_data(phy_tx_data), .phy_tx_last(phy_tx_last),
    .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .rx_out_last(rx_out_last),
    .tx_paused(tx_paused), .mac_media_rst(rst_out[5]), .backoff_rng_rst(rst_out[4]),
    .csl_rx_rst(rst_out[3]), .csl_tx_rst(rst_out[2]), .rx_fun_rst(rst_out[1]),
    .tx_fun_rst(rst_out[0]));
  emcf_phy_model phy (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_is_control(rx_is_control), .rx_is_pause(rx_is_pause),
    .rx_is_group(rx_is_group), .rx_hash_index(rx_hash_index));
  always #4 sys_clk = ~sys_clk;
  // cycle ceiling well above the hundred or so cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_byte(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    regq.push_back(e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // dst 0 expects nothing, 1 the phy side, 2 the receive output through loopback
  task tx(input int n, input logic pf, input int dst);
    logic [7:0] d;
    d = $urandom;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      tx_valid <= 1'b1;
      tx_data <= d + 8'(i);
      tx_last <= (i == n - 1);
      tx_pause_frame <= pf;
      if (dst == 1) txq.push_back({i == n - 1, d + 8'(i)});
      if (dst == 2) rxq.push_back({i == n - 1, d + 8'(i)});
    end
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    tx_data <= ~tx_data;
  endtask
  task rxf(input int n, input logic [2:0] f, input logic [5:0] ix, input logic acc);
    logic [7:0] d;
    d = $urandom;
    if (acc) for (int i = 0; i < n; i++) rxq.push_back({i == n - 1, d + 8'(i)});
    phy.send(n, f, ix, d);
  endtask
  always @(posedge sys_clk) rd_seen <= reg_rd;
  // outputs are judged mid-cycle, after the launching edge has settled
  always @(negedge sys_clk) begin
    if (rd_seen) chk_word(reg_rdata, regq.size() ? regq.pop_front() : 'x);
    if (rx_out_valid) chk_byte({rx_out_last, rx_out_data}, rxq.size() ? rxq.pop_front() : 'x);
    if (phy_tx_valid) chk_byte({phy_tx_last, phy_tx_data}, txq.size() ? txq.pop_front() : 'x);
  end
  initial begin
    h0 = $urandom(19);
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h08, 32'h0000800d);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    chk_word({26'h0, rst_out}, 32'h2f);
    wr(8'h08, 32'hffffffff);
    @(negedge sys_clk);
    chk_word({26'h0, rst_out}, 32'h3f);
    rd(8'h08, 32'h0000cf1f);
    wr(8'h08, 32'h00004000);
    @(negedge sys_clk);
    chk_word({26'h0, rst_out}, 32'h10);
    h0 = ($urandom | 32'h20) & ~32'h40;
    h1 = $urandom | 32'h100;
    wr(8'h00, h0);
    wr(8'h04, h1);
    rd(8'h00, h0);
    rd(8'h04, h1);
    // hash filter on: the table is locked while software leaves both it and the receive path enabled
    wr(8'h0c, 32'h3);
    wr(8'h00, ~h0);
    rd(8'h00, h0);
    wr(8'h08, 32'h00000001);
    rxf(3, 3'b001, 6'd5, 1'b1);
    rxf(3, 3'b001, 6'd6, 1'b0);
    rxf(2, 3'b001, 6'd40, 1'b1);
    rxf(2, 3'b000, 6'd6, 1'b1);
    rxf(2, 3'b100, 6'd0, 1'b0);
    wr(8'h08, 32'h00000003);
    rxf(2, 3'b100, 6'd0, 1'b1);
    tx(2, 1'b1, 0);
    tx(2, 1'b0, 1);
    wr(8'h08, 32'h0000000b);
    tx(2, 1'b1, 1);
    wr(8'h08, 32'h00000013);
    tx(3, 1'b0, 2);
    wr(8'h08, 32'h00000002);
    rxf(2, 3'b000, 6'd0, 1'b0);
    wr(8'h08, 32'h00000005);
    rxf(2, 3'b110, 6'd0, 1'b0);
    @(negedge sys_clk);
    chk_word({31'h0, tx_paused}, 32'h1);
    tx(2, 1'b0, 0);
    wr(8'h08, 32'h00000001);
    rxf(2, 3'b110, 6'd0, 1'b0);
    @(negedge sys_clk);
    chk_word({31'h0, tx_paused}, 32'h0);
    repeat (5) @(posedge sys_clk);
    chk_word(rxq.size() + txq.size() + regq.size(), 32'h0);
    print_verdict();
  end
endmodule
